// [logic/uc_pkg.sv]
// Package: register map, field positions, frame sizes and carrier types of the UART control block
package uc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [11:0] UC_IDX_FMT = 12'h013;
  localparam logic [11:0] UC_IDX_CTL = 12'h014;
  localparam logic [11:0] UC_IDX_NIN = 12'h015;
  localparam logic [11:0] UC_IDX_STS = 12'h016;
  localparam logic [11:0] UC_IDX_DAT = 12'h018;
  localparam logic [11:0] UC_ADDR_FMT = {UC_IDX_FMT[9:0], 2'b00};
  localparam logic [11:0] UC_ADDR_CTL = {UC_IDX_CTL[9:0], 2'b00};
  localparam logic [11:0] UC_ADDR_NIN = {UC_IDX_NIN[9:0], 2'b00};
  localparam logic [11:0] UC_ADDR_STS = {UC_IDX_STS[9:0], 2'b00};
  localparam logic [11:0] UC_ADDR_DAT = {UC_IDX_DAT[9:0], 2'b00};
  // frame_format_control fields
  localparam int UC_F_ODD = 0;
  localparam int UC_F_PAR = 1;
  localparam int UC_F_WAKE = 3;
  localparam int UC_F_NINE = 4;
  localparam int UC_F_MOD = 6;
  // irq_and_tx_rx_control fields
  localparam int UC_C_BRK = 0;
  localparam int UC_C_STBY = 1;
  localparam int UC_C_RXON = 2;
  localparam int UC_C_TXON = 3;
  localparam int UC_C_ILI = 4;
  localparam int UC_C_RFI = 5;
  localparam int UC_C_TCI = 6;
  localparam int UC_C_TEI = 7;
  // ninth_bit_error_irq_control fields
  localparam int UC_N_PEE = 0;
  localparam int UC_N_FEE = 1;
  localparam int UC_N_NEE = 2;
  localparam int UC_N_ORE = 3;
  localparam int UC_N_TX9 = 6;
  localparam int UC_N_RX9 = 7;
  // tx_rx_status fields; bits 5..0 are the receive flags
  localparam int UC_S_TBE = 7;
  localparam int UC_S_TC = 6;
  localparam int UC_RXF_W = 6;
  // Frame sizes in bit times
  localparam int UC_FRAME_W = 11;
  localparam logic [3:0] UC_LEN_SHORT = 4'ha;
  localparam logic [3:0] UC_LEN_LONG = 4'hb;
  localparam logic [3:0] UC_LEN_MARK = 4'h1;
  // Reset values of the transmit flags
  localparam logic UC_TBE_RST = 1'b1;
  localparam logic UC_TC_RST = 1'b1;
  // APB request bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } uc_apb_req_t;
  // Character events from the receive sampler
  typedef struct packed {
    logic valid;
    logic [8:0] data;
    logic idle;
    logic overrun;
    logic noise;
    logic framing;
    logic parity_err;
  } uc_rx_evt_t;
  // Transmit shifter state
  typedef enum logic {UC_TX_IDLE, UC_TX_SHIFT} uc_tx_st_t;
endpackage : uc_pkg

// [logic/uc_uart_ctrl.sv]
// Module: UART control, status flags and transmit shifter behind an APB slave
// Overview of operation
// - Parity on puts parity bit at MSB
// - Parity select: one odd, zero even
// - Start, 8-9 data/parity, stop: 10/11 bits
// - Empty enable gates empty flag to tx request
// - Done enable gates done flag to tx request
// - Full enable gates full flag to rx request
// - Idle enable gates idle flag to rx request
// - Enabling transmitter sends one-frame preamble of ones
// - Disabled transmitter finishes character, then idles high
// - Off-then-on mid-frame queues one idle character
// - Receiver off sets no receive flags; status-then-read still clears them
// - Standby hides rx requests until wake condition
// - Break bit sends breaks, then a one
// - Break toggled early replaces pending preamble
// - Received ninth bit: bit 8, or bit 7
// - Ninth transmit bit loads with data buffer
// - Four enables gate error flags to error request
// - Empty flag sets on transfer, clears status-then-write
// - Done flag set while nothing queued or sending
// - Full flag sets on transfer, clears status-then-read
// - Module off sets empty and done, masks tx
// - Nine-bit select chooses 9-bit characters
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
module uc_uart_ctrl
  import uc_pkg::*;
(
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RSTN,
  // APB slave
  input wire uc_apb_req_t I_APB,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Baud generator and receive sampler
  input wire logic I_BIT_TICK,
  input wire uc_rx_evt_t I_RX_EVT,
  // Serial line and requests
  output logic O_TXD,
  output logic O_RX_ON,
  output logic O_TX_IRQ,
  output logic O_RX_IRQ,
  output logic O_ERR_IRQ
);

  // Frame builder, LSB first: start, data, ninth or parity, stop
  function automatic logic [UC_FRAME_W-1:0] uc_frame(input logic [7:0] d, input logic b9,
      input logic nine, input logic par, input logic odd);
    logic p;
    logic [UC_FRAME_W-1:0] f;
    p = 1'b0;
    f = {UC_FRAME_W{1'b1}};
    f[8:1] = d;
    if (par) begin
      p = (nine ? (^d) : (^d[6:0])) ^ odd;
      if (nine) f[9] = p;
      else f[8] = p;
    end else if (nine) begin
      f[9] = b9;
    end
    f[0] = 1'b0;
    return f;
  endfunction : uc_frame

  // Frame length in bit times
  function automatic logic [3:0] uc_len(input logic nine);
    return nine ? UC_LEN_LONG : UC_LEN_SHORT;
  endfunction : uc_len

  // Bus handshake
  logic rdy_q;
  logic [31:0] prd_q;
  logic err_q;
  // Format and control fields
  logic odd_q, par_q, wake_q, nine_q, mod_q;
  logic tei_q, tci_q, rfi_q, ili_q, txon_q, rxon_q, stby_q, brk_q;
  logic ore_q, nee_q, fee_q, pee_q;
  // Fields that reset leaves alone
  logic rx9_q, tx9_q;
  logic [7:0] tdat_q, rdat_q;
  // Flags and their clear arming
  logic tbe_q, tc_q, tbe_arm_q;
  logic [UC_RXF_W-1:0] rxf_q, rx_arm_q;
  // Transmitter
  uc_tx_st_t st_q;
  logic [UC_FRAME_W-1:0] sh_q;
  logic [3:0] cnt_q;
  logic txd_q, pre_q, bkr_q, mark_q;
  // Requests
  logic txi_q, rxi_q, eri_q;

  // Decoded accesses, taken only at the access edge
  logic acc, wr, rd;
  logic wr_fmt, wr_ctl, wr_nin, wr_dat, rd_sts, rd_dat;
  logic mapped;
  logic [31:0] rdata;
  assign acc = I_APB.psel & I_APB.penable & rdy_q;
  assign wr = acc & I_APB.pwrite;
  assign rd = acc & ~I_APB.pwrite;
  assign wr_fmt = wr && I_APB.paddr == UC_ADDR_FMT;
  assign wr_ctl = wr && I_APB.paddr == UC_ADDR_CTL;
  assign wr_nin = wr && I_APB.paddr == UC_ADDR_NIN;
  assign wr_dat = wr && I_APB.paddr == UC_ADDR_DAT;
  assign rd_sts = rd && I_APB.paddr == UC_ADDR_STS;
  assign rd_dat = rd && I_APB.paddr == UC_ADDR_DAT;

  // Read mux; unused bits read zero
  always_comb begin
    rdata = '0;
    mapped = 1'b1;
    unique case (I_APB.paddr)
      UC_ADDR_FMT: begin
        rdata[UC_F_ODD] = odd_q;
        rdata[UC_F_PAR] = par_q;
        rdata[UC_F_WAKE] = wake_q;
        rdata[UC_F_NINE] = nine_q;
        rdata[UC_F_MOD] = mod_q;
      end
      UC_ADDR_CTL: rdata[7:0] = {tei_q, tci_q, rfi_q, ili_q, txon_q, rxon_q, stby_q, brk_q};
      UC_ADDR_NIN: begin
        rdata[UC_N_RX9] = rx9_q;
        rdata[UC_N_TX9] = tx9_q;
        rdata[UC_N_ORE] = ore_q;
        rdata[UC_N_NEE] = nee_q;
        rdata[UC_N_FEE] = fee_q;
        rdata[UC_N_PEE] = pee_q;
      end
      UC_ADDR_STS: rdata[7:0] = {tbe_q, tc_q, rxf_q};
      UC_ADDR_DAT: rdata[7:0] = rdat_q;
      default: mapped = 1'b0;
    endcase
  end

  // APB: ready rises on the setup edge, so every access has zero wait states
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      rdy_q <= 1'b0;
      prd_q <= '0;
      err_q <= 1'b0;
    end else begin
      rdy_q <= I_APB.psel & ~I_APB.penable;
      // Data captured at setup; address is stable through the access
      if (I_APB.psel & ~I_APB.penable) begin
        prd_q <= rdata;
        err_q <= ~mapped;
      end
    end
  end

  // Format register
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      odd_q <= 1'b0;
      par_q <= 1'b0;
      wake_q <= 1'b0;
      nine_q <= 1'b0;
      mod_q <= 1'b0;
    end else if (wr_fmt) begin
      odd_q <= I_APB.pwdata[UC_F_ODD];
      par_q <= I_APB.pwdata[UC_F_PAR];
      wake_q <= I_APB.pwdata[UC_F_WAKE];
      nine_q <= I_APB.pwdata[UC_F_NINE];
      mod_q <= I_APB.pwdata[UC_F_MOD];
    end
  end

  // Wake conditions: idle line, or address mark in the character MSB
  logic wake_idle, wake_mark;
  assign wake_idle = rxon_q & stby_q & ~wake_q & I_RX_EVT.idle;
  assign wake_mark = rxon_q & stby_q & wake_q & I_RX_EVT.valid &
                     (nine_q ? I_RX_EVT.data[8] : I_RX_EVT.data[7]);

  // Interrupt enables and tx/rx control
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      {tei_q, tci_q, rfi_q, ili_q} <= '0;
      txon_q <= 1'b0;
      rxon_q <= 1'b0;
      stby_q <= 1'b0;
      brk_q <= 1'b0;
    end else begin
      if (wr_ctl) begin
        {tei_q, tci_q, rfi_q, ili_q} <= I_APB.pwdata[UC_C_TEI:UC_C_ILI];
        txon_q <= I_APB.pwdata[UC_C_TXON];
        rxon_q <= I_APB.pwdata[UC_C_RXON];
        brk_q <= I_APB.pwdata[UC_C_BRK];
      end
      // Software setting standby wins over a wake in the same cycle
      if (wr_ctl && I_APB.pwdata[UC_C_STBY]) stby_q <= 1'b1;
      else if (wake_idle | wake_mark) stby_q <= 1'b0;
      else if (wr_ctl) stby_q <= 1'b0;
    end
  end

  // Error enables; ninth transmit bit keeps its value over reset
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      {ore_q, nee_q, fee_q, pee_q} <= '0;
    end else if (wr_nin) begin
      ore_q <= I_APB.pwdata[UC_N_ORE];
      nee_q <= I_APB.pwdata[UC_N_NEE];
      fee_q <= I_APB.pwdata[UC_N_FEE];
      pee_q <= I_APB.pwdata[UC_N_PEE];
    end
  end

  // Buffers and ninth bits without reset
  logic rx_take;
  assign rx_take = rxon_q & I_RX_EVT.valid & (~stby_q | wake_mark);
  always_ff @(posedge I_CLOCK) begin
    if (wr_nin) tx9_q <= I_APB.pwdata[UC_N_TX9];
    if (wr_dat) tdat_q <= I_APB.pwdata[7:0];
    if (rx_take) begin
      rdat_q <= I_RX_EVT.data[7:0];
      rx9_q <= nine_q ? I_RX_EVT.data[8] : I_RX_EVT.data[7];
    end
  end

  // Transmit scheduling: break beats preamble beats data
  logic idle_tx, load_brk, load_mark, load_pre, load_dat;
  assign idle_tx = mod_q & (st_q == UC_TX_IDLE);
  assign load_brk = idle_tx & (brk_q | bkr_q);
  assign load_mark = idle_tx & ~load_brk & mark_q;
  assign load_pre = idle_tx & ~load_brk & ~mark_q & pre_q;
  assign load_dat = idle_tx & txon_q & ~tbe_q & ~brk_q & ~bkr_q & ~mark_q & ~pre_q;

  // Pending preamble, break request and trailing mark bit
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN || !mod_q) begin
      pre_q <= 1'b0;
      bkr_q <= 1'b0;
      mark_q <= 1'b0;
    end else begin
      // Enable rising, also after a clear mid-frame, queues one idle frame
      if (wr_ctl && I_APB.pwdata[UC_C_TXON] && !txon_q) pre_q <= 1'b1;
      else if (load_pre || load_brk) pre_q <= 1'b0;
      // A quick set-and-clear still yields one break
      if (wr_ctl && I_APB.pwdata[UC_C_BRK]) bkr_q <= 1'b1;
      else if (load_brk) bkr_q <= 1'b0;
      // A lone one after the last break guarantees the next start bit; only a break ends low
      if (st_q == UC_TX_SHIFT && !sh_q[0] && cnt_q == UC_LEN_MARK && I_BIT_TICK && !brk_q)
        mark_q <= 1'b1;
      else if (load_mark) mark_q <= 1'b0;
    end
  end

  // Shifter; the last bit is held one bit time before the next load
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN || !mod_q) begin
      st_q <= UC_TX_IDLE;
      sh_q <= '1;
      cnt_q <= '0;
      txd_q <= 1'b1;
    end else if (st_q == UC_TX_IDLE) begin
      if (load_brk) sh_q <= '0;
      else if (load_mark) sh_q <= '1;
      else if (load_pre) sh_q <= '1;
      else if (load_dat) sh_q <= uc_frame(tdat_q, tx9_q, nine_q, par_q, odd_q);
      if (load_mark) cnt_q <= UC_LEN_MARK;
      else cnt_q <= uc_len(nine_q);
      if (load_brk | load_mark | load_pre | load_dat) st_q <= UC_TX_SHIFT;
      if (I_BIT_TICK) txd_q <= 1'b1;
    end else if (I_BIT_TICK) begin
      txd_q <= sh_q[0];
      sh_q <= {1'b1, sh_q[UC_FRAME_W-1:1]};
      cnt_q <= cnt_q - 4'h1;
      // Current frame always completes while the module is on, even with the transmitter off
      if (cnt_q == UC_LEN_MARK) st_q <= UC_TX_IDLE;
    end
  end

  // Transmit flags; a set in the clearing cycle wins
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      tbe_q <= UC_TBE_RST;
      tc_q <= UC_TC_RST;
      tbe_arm_q <= 1'b0;
    end else begin
      if (!mod_q || load_dat) tbe_q <= 1'b1;
      else if (wr_dat && tbe_arm_q) tbe_q <= 1'b0;
      if (rd_sts) tbe_arm_q <= prd_q[UC_S_TBE];
      else if (wr_dat) tbe_arm_q <= 1'b0;
      tc_q <= ~mod_q | (tbe_q & ~load_dat & (st_q == UC_TX_IDLE) & ~pre_q & ~bkr_q &
                        ~brk_q & ~mark_q);
    end
  end

  // Receive flags: full, idle, overrun, noise, framing, parity
  logic [UC_RXF_W-1:0] rx_set;
  always_comb begin
    rx_set = '0;
    if (rxon_q && !stby_q) begin
      rx_set = {1'b0, I_RX_EVT.idle, I_RX_EVT.overrun, I_RX_EVT.noise, I_RX_EVT.framing,
                I_RX_EVT.parity_err};
    end
    rx_set[UC_RXF_W-1] = rx_take;
  end

  // Status read arms, data read clears only the armed flags
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      rxf_q <= '0;
      rx_arm_q <= '0;
    end else begin
      rxf_q <= rx_set | (rxf_q & ~(rd_dat ? rx_arm_q : '0));
      if (rd_sts) rx_arm_q <= prd_q[UC_RXF_W-1:0];
      else if (rd_dat) rx_arm_q <= '0;
    end
  end

  // Interrupt requests, registered
  always_ff @(posedge I_CLOCK) begin
    if (!I_RSTN) begin
      txi_q <= 1'b0;
      rxi_q <= 1'b0;
      eri_q <= 1'b0;
    end else begin
      txi_q <= mod_q & ((tbe_q & tei_q) | (tc_q & tci_q));
      rxi_q <= ~stby_q & ((rxf_q[5] & rfi_q) | (rxf_q[4] & ili_q));
      eri_q <= |(rxf_q[3:0] & {ore_q, nee_q, fee_q, pee_q});
    end
  end

  // Outputs straight from flip-flops
  assign O_PRDATA = prd_q;
  assign O_PREADY = rdy_q;
  assign O_PSLVERR = err_q;
  assign O_TXD = txd_q;
  assign O_RX_ON = rxon_q;
  assign O_TX_IRQ = txi_q;
  assign O_RX_IRQ = rxi_q;
  assign O_ERR_IRQ = eri_q;

  // Checks
  off_sets_tbe_a: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
    !mod_q |=> tbe_q && tc_q) else $error("module off did not set flags");
  tbe_set_a: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
    load_dat |=> tbe_q && !tc_q) else $error("transfer did not set empty flag");
  tbe_clear_a: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
    mod_q && wr_dat && tbe_arm_q |=> !tbe_q) else $error("empty flag not cleared");
  rxf_set_a: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
    rx_take |=> rxf_q[5]) else $error("full flag not set");
  tx_irq_a: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
    mod_q && tbe_q && tei_q |=> O_TX_IRQ) else $error("tx request missing");
  done_irq_a: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
    mod_q && tc_q && tci_q |=> O_TX_IRQ) else $error("done request missing");
  rx_irq_a: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
    !stby_q && rxf_q[5] && rfi_q |=> O_RX_IRQ) else $error("rx request missing");
  idle_irq_a: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
    !stby_q && rxf_q[4] && ili_q |=> O_RX_IRQ) else $error("idle request missing");
  stby_mask_a: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
    stby_q |=> !O_RX_IRQ) else $error("rx request during standby");
  err_irq_a: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
    rxf_q[2] && nee_q |=> O_ERR_IRQ) else $error("noise request missing");
  preamble_a: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
    load_pre |=> sh_q == '1 && cnt_q == uc_len($past(nine_q))) else $error("bad preamble");
  break_a: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
    load_brk |=> sh_q == '0 && !pre_q) else $error("bad break load");
  parity_a: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
    load_dat && par_q && !nine_q |=> sh_q[8] == ((^$past(tdat_q[6:0])) ^ $past(odd_q)))
    else $error("bad parity bit");
  frame_a: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
    load_dat |=> !sh_q[0] && sh_q[10] && cnt_q == ($past(nine_q) ? UC_LEN_LONG : UC_LEN_SHORT))
    else $error("bad frame shape");
  idle_high_a: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
    st_q == UC_TX_IDLE && I_BIT_TICK |=> O_TXD) else $error("line not idle high");
  ninth_a: assert property (@(posedge I_CLOCK) disable iff (!I_RSTN)
    rx_take && nine_q |=> rx9_q == $past(I_RX_EVT.data[8])) else $error("bad ninth bit");

endmodule : uc_uart_ctrl

// [tb/uc_far_end.sv]
// Far-end model: baud ticks, receive events and capture of frames on the serial output
`timescale 1ns/1ns
module uc_far_end
  import uc_pkg::*;
#(
  parameter int TICK_DIV = 8
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Serial line and format
  input wire logic i_txd,
  input wire logic i_nine,
  input wire uc_rx_evt_t i_evt,
  // Towards the block and the bench
  output logic o_tick,
  output uc_rx_evt_t o_evt,
  output logic o_fr_valid,
  output logic [10:0] o_fr
);
  logic [3:0] div_q; // Bit-time divider
  logic tick_d1_q; // Tick seen one cycle late, sampling one cycle after each bit change
  logic busy_q; // Inside a frame
  logic [3:0] cnt_q; // Next bit position
  // Bit tick runs free; the baud generator never pauses
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      div_q <= 4'h0;
      o_tick <= 1'b0;
    end else begin
      o_tick <= (div_q == 4'(TICK_DIV - 1));
      div_q <= (div_q == 4'(TICK_DIV - 1)) ? 4'h0 : div_q + 4'h1;
    end
  end
  // Receive events pass through one register, one cycle each
  always_ff @(posedge i_clk) begin
    if (!i_rstn) o_evt <= '0;
    else o_evt <= i_evt;
  end
  // Frame capture: a low start bit opens 10 or 11 bit times, LSB first
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      tick_d1_q <= 1'b0;
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      o_fr <= 11'h000;
      o_fr_valid <= 1'b0;
    end else begin
      tick_d1_q <= o_tick;
      o_fr_valid <= 1'b0;
      if (tick_d1_q && !busy_q && !i_txd) begin
        busy_q <= 1'b1;
        cnt_q <= 4'h1;
        o_fr <= 11'h000;
      end else if (tick_d1_q && busy_q) begin
        o_fr[cnt_q] <= i_txd;
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == (i_nine ? UC_LEN_LONG : UC_LEN_SHORT) - 4'h1) begin
          busy_q <= 1'b0;
          o_fr_valid <= 1'b1;
        end
      end
    end
  end
endmodule : uc_far_end

// [tb/tb_uart_control_and_status.sv]
// Testbench: register, transmit, receive and request checks of the UART control block
`timescale 1ns/1ns
module tb_uart_control_and_status;
  import uc_pkg::*;
  // Expected APB answer: value, defined bits, error
  typedef struct {logic [7:0] v; logic [7:0] m; logic e;} uc_exp_t;
  localparam int TICK = 8;
  logic clk, rstn, pready, pslverr, txd, rx_on, tx_irq, rx_irq, err_irq, tick, fr_valid, nine;
  logic [31:0] prdata;
  logic [10:0] fr;
  uc_apb_req_t apb;
  uc_rx_evt_t evt_req, evt;
  uc_exp_t rq[$]; // Notes for bus answers
  logic [10:0] fq[$]; // Notes for frames
  int n_mismatch = 0;
  int n_tests = 0;
  uc_uart_ctrl i_uc_uart_ctrl (.I_CLOCK(clk), .I_RSTN(rstn), .I_APB(apb), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_BIT_TICK(tick), .I_RX_EVT(evt), .O_TXD(txd),
    .O_RX_ON(rx_on), .O_TX_IRQ(tx_irq), .O_RX_IRQ(rx_irq), .O_ERR_IRQ(err_irq));
  uc_far_end #(.TICK_DIV(TICK)) i_uc_far_end (.i_clk(clk), .i_rstn(rstn), .i_txd(txd),
    .i_nine(nine), .i_evt(evt_req), .o_tick(tick), .o_evt(evt), .o_fr_valid(fr_valid), .o_fr(fr));
  // Clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Single compare point
  task automatic chk(input string what, input logic [10:0] seen, input logic [10:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  // One APB transfer; holds the request until pready is sampled high
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d,
                      input logic [7:0] ev, input logic [7:0] em, input logic ee);
    rq.push_back('{ev, em, ee});
    @(posedge clk);
    apb <= '{1'b1, 1'b0, wr, a, {24'h0, d}};
    @(posedge clk);
    apb.penable <= 1'b1;
    // Only the watchdog ends a wait for ready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    apb <= '0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, 8'h00, 8'h00, 1'b0);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] ev, input logic [7:0] em);
    xfer(1'b0, a, 8'h00, ev, em, 1'b0);
  endtask : rd
  // Frame image as the far end captures it, start bit in bit 0
  function automatic logic [10:0] frame_of(input logic [7:0] d, input logic nn, input logic p,
                                           input logic o, input logic t9);
    logic [10:0] f;
    f = {2'b00, d, 1'b0};
    if (!nn && p) f[8] = ^d[6:0] ^ o;
    if (nn) f[9] = p ? (^d ^ o) : t9;
    f[nn ? 10 : 9] = 1'b1;
    return f;
  endfunction : frame_of
  // One receive event, then time for flag and request to settle
  task automatic rx_evt(input logic v, input logic [8:0] dd, input logic idl, input logic fe);
    @(posedge clk);
    evt_req <= '{v, dd, idl, 1'b0, 1'b0, fe, 1'b0};
    @(posedge clk);
    evt_req <= '0;
    repeat (4) @(posedge clk);
  endtask : rx_evt
  // Wait for noted frames, then for the stop bit to end
  task automatic drain();
    // A frame that never comes is left to the watchdog
    while (fq.size() > 0) begin
      @(posedge clk);
    end
    repeat (3 * TICK) @(posedge clk);
  endtask : drain
  task automatic print_verdict();
    // Notes that never met their answer count as mismatches
    if (rq.size() > 0 || fq.size() > 0) n_mismatch++;
    $display("Counts: %0d checks, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  // Scoreboard: oldest note against each answer and each frame
  always @(posedge clk) begin
    if (apb.psel && apb.penable && pready === 1'b1 && rq.size() > 0) begin
      chk("read data", 11'(prdata[7:0] & rq[0].m), 11'(rq[0].v & rq[0].m));
      chk("bus error", 11'(pslverr), 11'(rq[0].e));
      void'(rq.pop_front());
    end
    // An unnoted frame is compared with an impossible image
    if (fr_valid === 1'b1) chk("frame", fr, (fq.size() > 0) ? fq.pop_front() : 11'h7ff);
  end
  // Hang guard, far above the expected run time
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end
  // Main sequence
  initial begin
    logic [7:0] d;
    logic t9;
    int i;
    apb = '0;
    evt_req = '0;
    rstn = 1'b0;
    nine = 1'b0;
    void'($urandom(32'hdf07));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rd(UC_ADDR_STS, 8'hc0, 8'hff);
    rd(UC_ADDR_CTL, 8'h00, 8'hff);
    rd(UC_ADDR_FMT, 8'h00, 8'hff);
    rd(UC_ADDR_NIN, 8'h00, 8'h07);
    xfer(1'b0, 12'h0fc, 8'h00, 8'h00, 8'hff, 1'b1);
    $display("Test reset values done");
    // Every format row, random data and ninth bit
    for (i = 0; i < 6; i++) begin
      d = 8'($urandom);
      t9 = 1'($urandom);
      nine <= i[0];
      wr(UC_ADDR_FMT, {3'b010, i[0], 2'b00, i >= 2, i >= 4}); // only between frames
      wr(UC_ADDR_NIN, {1'b0, t9, 6'h00});
      if (i == 0) wr(UC_ADDR_CTL, 8'h08);
      rd(UC_ADDR_STS, 8'h80, 8'h80);
      fq.push_back(frame_of(d, i[0], i >= 2, i >= 4, t9));
      wr(UC_ADDR_DAT, d);
      rd(UC_ADDR_STS, 8'h00, 8'h40);
      if (i == 5) wr(UC_ADDR_CTL, 8'h00);
      drain();
      rd(UC_ADDR_STS, 8'hc0, 8'hc0);
    end
    chk("idle line", 11'(txd), 11'h001);
    $display("Test transmit formats done");
    nine <= 1'b0;
    wr(UC_ADDR_FMT, 8'h40);
    wr(UC_ADDR_NIN, 8'h02);
    wr(UC_ADDR_CTL, 8'h34);
    d = 8'($urandom);
    rx_evt(1'b1, {1'($urandom), d}, 1'b0, 1'b0);
    chk("rx irq", 11'(rx_irq), 11'h001);
    rd(UC_ADDR_STS, 8'he0, 8'hff);
    rd(UC_ADDR_DAT, d, 8'hff);
    rd(UC_ADDR_NIN, {d[7], 7'h02}, 8'hff);
    rd(UC_ADDR_STS, 8'hc0, 8'hff);
    rx_evt(1'b0, 9'h000, 1'b1, 1'b0);
    chk("idle irq", 11'(rx_irq), 11'h001);
    wr(UC_ADDR_CTL, 8'h10); // Receiver off with idle pending
    rd(UC_ADDR_STS, 8'hd0, 8'hff);
    chk("rx enable", 11'(rx_on), 11'h000);
    rd(UC_ADDR_DAT, 8'h00, 8'h00);
    wr(UC_ADDR_CTL, 8'h04);
    rx_evt(1'b0, 9'h000, 1'b0, 1'b1);
    chk("err irq", 11'(err_irq), 11'h001);
    rd(UC_ADDR_STS, 8'hc2, 8'hff);
    rd(UC_ADDR_DAT, 8'h00, 8'h00);
    wr(UC_ADDR_CTL, 8'h26); // Standby, idle-line wake
    rx_evt(1'b1, 9'h055, 1'b0, 1'b0);
    chk("standby irq", 11'(rx_irq), 11'h000);
    rd(UC_ADDR_STS, 8'hc0, 8'hff);
    rx_evt(1'b0, 9'h000, 1'b1, 1'b0);
    rd(UC_ADDR_CTL, 8'h24, 8'hff);
    $display("Test receive flags done");
    // Break toggled before the pending preamble goes out
    wr(UC_ADDR_CTL, 8'h00);
    fq.push_back(11'h000);
    wr(UC_ADDR_CTL, 8'h09);
    wr(UC_ADDR_CTL, 8'h08);
    drain();
    rd(UC_ADDR_STS, 8'hc0, 8'hc0);
    chk("tx irq", 11'(tx_irq), 11'h000);
    $display("Test break done");
    wr(UC_ADDR_CTL, 8'h48);
    repeat (3) @(posedge clk);
    chk("done irq", 11'(tx_irq), 11'h001);
    wr(UC_ADDR_CTL, 8'h88);
    repeat (3) @(posedge clk);
    chk("empty irq", 11'(tx_irq), 11'h001);
    wr(UC_ADDR_FMT, 8'h00);
    repeat (3) @(posedge clk);
    chk("off irq", 11'(tx_irq), 11'h000);
    rd(UC_ADDR_STS, 8'hc0, 8'hc0);
    repeat (3) @(posedge clk);
    $display("Test transmit requests done");
    print_verdict();
  end
endmodule : tb_uart_control_and_status
